// >>> smc_pkg.sv
// shared constants for the serial link configuration bank
package smc_pkg;
    // register byte addresses
    localparam logic [17:0] SMC_OFS_GLOBAL = 18'h130C4;
    localparam logic [17:0] SMC_OFS_LINK_CTL = 18'h130C8;
    localparam int SMC_ADDR_W = 18;

    // global SerDes register, fields counted from the lsb
    localparam logic [31:0] SMC_GLOBAL_RESET = 32'h0023014F;
    localparam logic [31:0] SMC_GLOBAL_WMASK = 32'h003FFFC0;
    localparam int SMC_PRESCALE_LSB = 20;
    localparam logic [1:0] SMC_PRESCALE_DIV2 = 2'h2;

    // link control register fields, counted from the lsb
    localparam int SMC_DEAD_LINK_TIMER_ENABLE_BIT = 31;
    localparam int SMC_THRESH_LSB = 16;
    localparam int SMC_THRESH_W = 15;
    localparam int SMC_LINE_LOOPBACK_LANES_LSB = 12;
    localparam int SMC_PAIRING_BIT = 10;
    localparam int SMC_ODD_LB_BIT = 9;
    localparam int SMC_EVEN_LB_BIT = 8;
    localparam int SMC_TX_REV_BIT = 7;
    localparam int SMC_RX_REV_BIT = 6;
    localparam int SMC_ODD_SRST_BIT = 5;
    localparam int SMC_EVEN_SRST_BIT = 4;
    localparam int SMC_ODD_PWDN_BIT = 3;
    localparam logic [31:0] SMC_LINK_CTL_RESET = 32'h7FFF0000;
    localparam logic [31:0] SMC_LINK_CTL_WMASK = 32'hFFFFFFF8;

    // dead link timing: one unit is 2^13 periods of 10 ns, counted in 8 ns core cycles
    localparam int SMC_DLT_UNIT_NS = 8192 * 10;
    localparam int SMC_CLK_PERIOD_NS = 8;
    localparam int SMC_DLT_UNIT_CYCLES = SMC_DLT_UNIT_NS / SMC_CLK_PERIOD_NS;

    // ports sharing this serial interface: 0 even, 1 odd
    localparam int SMC_NUM_PORTS = 2;
    localparam int SMC_NUM_LANES = 4;
endpackage : smc_pkg

// >>> smc_link_cfg.sv
// register bank and dead link timers for one serial interface pair
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module smc_link_cfg
    import smc_pkg::*;
#(
    parameter int DLT_UNIT_CYCLES = SMC_DLT_UNIT_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [SMC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // strap pins
    input wire logic i_pairing_config_pin,
    input wire logic i_tx_reverse_pin,
    input wire logic i_rx_reverse_pin,
    input wire logic i_odd_power_down_pin,
    // link status and transmit queue, index 0 even, 1 odd
    input wire logic [SMC_NUM_PORTS-1:0] i_link_silence,
    input wire logic [SMC_NUM_PORTS-1:0] i_link_up,
    input wire logic [SMC_NUM_PORTS-1:0] i_tx_pkt_valid,
    output logic [SMC_NUM_PORTS-1:0] o_tx_dead,
    output logic [SMC_NUM_PORTS-1:0] o_tx_flush,
    output logic [SMC_NUM_PORTS-1:0] o_tx_pkt_drop,
    // configuration outputs
    output logic [1:0] o_pll_ref_divider,
    output logic o_pll_ref_div_by_two,
    output logic [31:0] o_serdes_global_cfg,
    output logic [SMC_NUM_LANES-1:0] o_line_loopback_lanes,
    output logic o_port_pairing_select,
    output logic o_odd_port_local_loopback,
    output logic o_even_port_local_loopback,
    output logic o_tx_lane_reverse,
    output logic o_rx_lane_reverse,
    output logic o_odd_port_soft_reset,
    output logic o_even_port_soft_reset,
    output logic o_odd_port_power_down
);

    localparam logic [13:0] UNIT_LAST = 14'(DLT_UNIT_CYCLES - 1);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [31:0] global_q;
    logic [31:0] link_ctl_q;
    logic strap_load_q;
    logic div2_q;
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic req_seen;
    logic wr_take;
    logic [14:0] thresh;
    logic timer_on;
    logic [SMC_NUM_PORTS-1:0] port_srst;
    logic [SMC_NUM_PORTS-1:0] dead_q;
    logic [SMC_NUM_PORTS-1:0] armed_q;
    logic [SMC_NUM_PORTS-1:0] flush_q;
    logic [SMC_NUM_PORTS-1:0] drop_q;
    logic [14:0] cnt_q [SMC_NUM_PORTS];
    logic [13:0] sub_q [SMC_NUM_PORTS];

    // bus handshake: one wait cycle, then an answer
    assign req_seen = (i_avs_read || i_avs_write) && waitreq_q;
    assign wr_take = i_avs_write && !waitreq_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            waitreq_q <= 1'b1;
        end else if (req_seen) begin
            waitreq_q <= 1'b0;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    // read data stand while waitrequest is low; unmapped reads zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h00000000;
        end else if (req_seen && i_avs_read) begin
            unique case (i_avs_address)
                SMC_OFS_GLOBAL: rdata_q <= global_q;
                SMC_OFS_LINK_CTL: rdata_q <= link_ctl_q & SMC_LINK_CTL_WMASK;
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    // global serdes register, read-only bits pinned
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            global_q <= SMC_GLOBAL_RESET;
        end else if (wr_take && i_avs_address == SMC_OFS_GLOBAL) begin
            global_q <= (be_merge(global_q, i_avs_writedata, i_avs_byteenable)
                         & SMC_GLOBAL_WMASK) | (SMC_GLOBAL_RESET & ~SMC_GLOBAL_WMASK);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div2_q <= 1'b1;
        end else begin
            div2_q <= global_q[SMC_PRESCALE_LSB +: 2] == SMC_PRESCALE_DIV2;
        end
    end

    // strap pins arrive asynchronously
    always_ff @(posedge i_clk) begin
        pin_meta_q <= {i_odd_power_down_pin, i_rx_reverse_pin,
                       i_tx_reverse_pin, i_pairing_config_pin};
        pin_sync_q <= pin_meta_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            strap_load_q <= 1'b1;
        end else begin
            strap_load_q <= 1'b0;
        end
    end

    // link control register; straps load on the first cycle after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            link_ctl_q <= SMC_LINK_CTL_RESET;
        end else if (strap_load_q) begin
            link_ctl_q[SMC_PAIRING_BIT] <= pin_sync_q[0];
            link_ctl_q[SMC_TX_REV_BIT] <= pin_sync_q[1];
            link_ctl_q[SMC_RX_REV_BIT] <= pin_sync_q[2];
            link_ctl_q[SMC_ODD_PWDN_BIT] <= pin_sync_q[3];
        end else if (wr_take && i_avs_address == SMC_OFS_LINK_CTL) begin
            // applied at once, no retraining wait
            link_ctl_q <= be_merge(link_ctl_q, i_avs_writedata, i_avs_byteenable)
                          & SMC_LINK_CTL_WMASK;
        end
    end

    assign thresh = link_ctl_q[SMC_THRESH_LSB +: SMC_THRESH_W];
    assign timer_on = link_ctl_q[SMC_DEAD_LINK_TIMER_ENABLE_BIT] && (thresh != 15'h0000);
    assign port_srst = {link_ctl_q[SMC_ODD_SRST_BIT], link_ctl_q[SMC_EVEN_SRST_BIT]};

    // one dead link timer per port, core clock
    for (genvar p = 0; p < SMC_NUM_PORTS; p++) begin : g_port
        always_ff @(posedge i_clk) begin
            if (i_rst || port_srst[p]) begin
                armed_q[p] <= 1'b0;
                dead_q[p] <= 1'b0;
                flush_q[p] <= 1'b0;
                cnt_q[p] <= 15'h0000;
                sub_q[p] <= 14'h0000;
            end else begin
                flush_q[p] <= 1'b0;
                if (i_link_up[p]) begin
                    armed_q[p] <= 1'b0;
                    dead_q[p] <= 1'b0;
                end else if (!timer_on) begin
                    armed_q[p] <= 1'b0;
                end else if (i_link_silence[p]) begin
                    armed_q[p] <= 1'b1;
                    cnt_q[p] <= thresh;
                    sub_q[p] <= UNIT_LAST;
                end else if (armed_q[p]) begin
                    // (thresh+1) units of 8192 x 10 ns
                    if (sub_q[p] != 14'h0000) begin
                        sub_q[p] <= sub_q[p] - 14'h0001;
                    end else if (cnt_q[p] != 15'h0000) begin
                        sub_q[p] <= UNIT_LAST;
                        cnt_q[p] <= cnt_q[p] - 15'h0001;
                    end else begin
                        armed_q[p] <= 1'b0;
                        dead_q[p] <= 1'b1;
                        flush_q[p] <= !dead_q[p];
                    end
                end
            end
        end

        // packets offered to a dead port are dropped
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                drop_q[p] <= 1'b0;
            end else begin
                drop_q[p] <= dead_q[p] && i_tx_pkt_valid[p];
            end
        end
    end

    assign o_avs_waitrequest = waitreq_q;
    assign o_avs_readdata = rdata_q;
    assign o_tx_dead = dead_q;
    assign o_tx_flush = flush_q;
    assign o_tx_pkt_drop = drop_q;
    assign o_pll_ref_divider = global_q[SMC_PRESCALE_LSB +: 2];
    assign o_pll_ref_div_by_two = div2_q;
    assign o_serdes_global_cfg = global_q;
    assign o_line_loopback_lanes = link_ctl_q[SMC_LINE_LOOPBACK_LANES_LSB +: SMC_NUM_LANES];
    assign o_port_pairing_select = link_ctl_q[SMC_PAIRING_BIT];
    assign o_odd_port_local_loopback = link_ctl_q[SMC_ODD_LB_BIT];
    assign o_even_port_local_loopback = link_ctl_q[SMC_EVEN_LB_BIT];
    assign o_tx_lane_reverse = link_ctl_q[SMC_TX_REV_BIT];
    assign o_rx_lane_reverse = link_ctl_q[SMC_RX_REV_BIT];
    assign o_odd_port_soft_reset = link_ctl_q[SMC_ODD_SRST_BIT];
    assign o_even_port_soft_reset = link_ctl_q[SMC_EVEN_SRST_BIT];
    assign o_odd_port_power_down = link_ctl_q[SMC_ODD_PWDN_BIT];

    // checks
    sequence s_bus_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence

    sequence s_bus_ans;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    property p_bus_answer;
        @(posedge i_clk) disable iff (i_rst)
        s_bus_req |=> s_bus_ans;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered after one wait cycle");

    property p_global_reset;
        @(posedge i_clk)
        i_rst |=> o_serdes_global_cfg == SMC_GLOBAL_RESET;
    endproperty
    a_global_reset: assert property (p_global_reset)
        else $error("global register reset value wrong");

    property p_div_by_two;
        @(posedge i_clk) disable iff (i_rst)
        ##1 (o_pll_ref_div_by_two == ($past(o_pll_ref_divider) == SMC_PRESCALE_DIV2));
    endproperty
    a_div_by_two: assert property (p_div_by_two)
        else $error("divide by two flag disagrees with prescaler code");

    property p_link_reset;
        @(posedge i_clk)
        i_rst |=> thresh == 15'h7FFF && !o_tx_dead[0] && !o_tx_dead[1]
            && !link_ctl_q[SMC_DEAD_LINK_TIMER_ENABLE_BIT];
    endproperty
    a_link_reset: assert property (p_link_reset)
        else $error("link control reset values wrong");

    property p_zero_thresh;
        @(posedge i_clk) disable iff (i_rst)
        (thresh == 15'h0000) |=> !armed_q[0] && !armed_q[1];
    endproperty
    a_zero_thresh: assert property (p_zero_thresh)
        else $error("timer armed with zero threshold");

    property p_dead_flush;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_tx_dead[0]) |-> o_tx_flush[0] && $past(cnt_q[0]) == 15'h0000
            && $past(sub_q[0]) == 14'h0000;
    endproperty
    a_dead_flush: assert property (p_dead_flush)
        else $error("dead declared without countdown end or flush");

    property p_drop;
        @(posedge i_clk) disable iff (i_rst)
        o_tx_dead[1] && i_tx_pkt_valid[1] |=> o_tx_pkt_drop[1];
    endproperty
    a_drop: assert property (p_drop)
        else $error("packet to dead port not dropped");

    property p_link_up_clears;
        @(posedge i_clk) disable iff (i_rst)
        i_link_up[0] |=> !o_tx_dead[0];
    endproperty
    a_link_up_clears: assert property (p_link_up_clears)
        else $error("dead state survived link up");

    property p_odd_soft_reset;
        @(posedge i_clk) disable iff (i_rst)
        o_odd_port_soft_reset |=> !o_tx_dead[1] && !o_tx_flush[1];
    endproperty
    a_odd_soft_reset: assert property (p_odd_soft_reset)
        else $error("odd port active under soft reset");

    property p_strap;
        @(posedge i_clk) disable iff (i_rst)
        strap_load_q |=> o_port_pairing_select == $past(pin_sync_q[0])
            && o_tx_lane_reverse == $past(pin_sync_q[1]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not loaded after reset");

    sequence s_even_silence;
        timer_on && !i_link_up[0] && !port_srst[0] && i_link_silence[0];
    endsequence

    property p_silence_reload;
        @(posedge i_clk) disable iff (i_rst)
        s_even_silence |=> armed_q[0] && cnt_q[0] == $past(thresh);
    endproperty
    a_silence_reload: assert property (p_silence_reload)
        else $error("silence did not reload the countdown");

    property p_flush_pulse;
        @(posedge i_clk) disable iff (i_rst)
        o_tx_flush[1] |=> !o_tx_flush[1];
    endproperty
    a_flush_pulse: assert property (p_flush_pulse)
        else $error("flush pulse longer than one cycle");

    property p_even_soft_reset;
        @(posedge i_clk) disable iff (i_rst)
        o_even_port_soft_reset |=> !o_tx_dead[0] && !o_tx_flush[0];
    endproperty
    a_even_soft_reset: assert property (p_even_soft_reset)
        else $error("even port active under soft reset");

    property p_no_drop_alive;
        @(posedge i_clk) disable iff (i_rst)
        !o_tx_dead[0] |=> !o_tx_pkt_drop[0];
    endproperty
    a_no_drop_alive: assert property (p_no_drop_alive)
        else $error("packet dropped while link alive");

    property p_global_fixed;
        @(posedge i_clk) disable iff (i_rst)
        (o_serdes_global_cfg & ~SMC_GLOBAL_WMASK) == (SMC_GLOBAL_RESET & ~SMC_GLOBAL_WMASK);
    endproperty
    a_global_fixed: assert property (p_global_fixed)
        else $error("read-only global bits changed");

    sequence s_ctl_write;
        i_avs_write && !o_avs_waitrequest && i_avs_address == SMC_OFS_LINK_CTL
            && i_avs_byteenable == 4'hF;
    endsequence

    property p_ctl_write;
        @(posedge i_clk) disable iff (i_rst)
        s_ctl_write |=> link_ctl_q == ($past(i_avs_writedata) & SMC_LINK_CTL_WMASK);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("control write not applied at once");

endmodule : smc_link_cfg
`default_nettype wire

// >>> smc_link_partner.sv
// serial link partner model: silence pulses, link-up level, packet offers
`timescale 1ns/1ns
`default_nettype none
module smc_link_partner
    import smc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bench commands, index 0 even, 1 odd
    input wire logic [SMC_NUM_PORTS-1:0] i_go_silent,
    input wire logic [SMC_NUM_PORTS-1:0] i_answer,
    input wire logic [SMC_NUM_PORTS-1:0] i_offer,
    // toward the configuration bank
    output logic [SMC_NUM_PORTS-1:0] o_link_silence,
    output logic [SMC_NUM_PORTS-1:0] o_link_up,
    output logic [SMC_NUM_PORTS-1:0] o_tx_pkt_valid
);
    logic [SMC_NUM_PORTS-1:0] silent_q;

    // one silence pulse each time a port is told to go silent
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            silent_q <= '0;
            o_link_silence <= '0;
            o_link_up <= '0;
            o_tx_pkt_valid <= '0;
        end else begin
            silent_q <= i_go_silent;
            o_link_silence <= i_go_silent & ~silent_q;
            o_link_up <= i_answer;
            o_tx_pkt_valid <= i_offer;
        end
    end
endmodule : smc_link_partner
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the serial link configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import smc_pkg::*;
;
    typedef struct {logic [17:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e;} smc_row_t;
    localparam int UNIT = 4;
    localparam logic [17:0] G = 18'h130C4;
    localparam logic [17:0] L = 18'h130C8;
    logic clk = 1'b0;
    logic rst, rd, wr;
    logic [17:0] addr;
    logic [31:0] wdata, q;
    logic [3:0] be, pins;
    logic [1:0] go, answer, offer;
    wire [1:0] silence, up, valid, dead, flush, drop, div;
    wire [31:0] rdata, gcfg;
    wire [11:0] cfg;
    wire waitreq, div2;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    smc_row_t rows [10] = '{
        '{G, 32'h00000000, 4'h4, 32'h0000014F}, '{G, 32'h00100000, 4'h4, 32'h0010014F},
        '{G, 32'h00300000, 4'h4, 32'h0030014F}, '{G, 32'h00200000, 4'h4, 32'h0020014F},
        '{G, 32'hFFFFFFFF, 4'hB, 32'h0020FFCF}, '{G, 32'h0023014F, 4'hF, 32'h0023014F},
        '{L, 32'hFFFFFFFF, 4'hF, 32'hFFFFFFF8}, '{L, 32'h00000000, 4'hF, 32'h00000000},
        '{18'h130CC, 32'hFFFFFFFF, 4'hF, 32'h0}, '{L, 32'h12345678, 4'h1, 32'h00000078}};
    logic [31:0] cv [2] = '{32'h0000FFF8, 32'h00005A50};
    logic [11:0] ce [2] = '{12'hFFF, 12'h54A};

    smc_link_cfg #(.DLT_UNIT_CYCLES(UNIT)) smc_link_cfg_inst (
        .i_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_pairing_config_pin(pins[0]),
        .i_tx_reverse_pin(pins[1]), .i_rx_reverse_pin(pins[2]), .i_odd_power_down_pin(pins[3]),
        .i_link_silence(silence), .i_link_up(up), .i_tx_pkt_valid(valid), .o_tx_dead(dead),
        .o_tx_flush(flush), .o_tx_pkt_drop(drop), .o_pll_ref_divider(div),
        .o_pll_ref_div_by_two(div2), .o_serdes_global_cfg(gcfg),
        .o_line_loopback_lanes(cfg[11:8]), .o_port_pairing_select(cfg[7]),
        .o_odd_port_local_loopback(cfg[6]), .o_even_port_local_loopback(cfg[5]),
        .o_tx_lane_reverse(cfg[4]), .o_rx_lane_reverse(cfg[3]), .o_odd_port_soft_reset(cfg[2]),
        .o_even_port_soft_reset(cfg[1]), .o_odd_port_power_down(cfg[0]));
    smc_link_partner smc_link_partner_inst (
        .i_clk(clk), .i_rst(rst), .i_go_silent(go), .i_answer(answer), .i_offer(offer),
        .o_link_silence(silence), .o_link_up(up), .o_tx_pkt_valid(valid));

    always #4 clk = ~clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        be <= b;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        chk("bus_wait", 32'h2, n);
    endtask : bus

    // silence on port p; exp_n cycles to dead, zero when it must stay alive
    task automatic fire(input int p, input int exp_n);
        int n;
        n = 0;
        @(posedge clk);
        go[p] <= 1'b1;
        @(posedge clk);
        go[p] <= 1'b0;
        while (silence[p] !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (dead[p] !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (exp_n == 0) begin
            chk("dead_held_off", 32'h0, {31'h0, dead[p]});
        end else begin
            chk("dead_delay", exp_n, n);
            chk("flush_on", 32'h1, {31'h0, flush[p]});
            chk("other_alive", 32'h0, {31'h0, dead[1-p]});
            @(negedge clk);
            chk("flush_off", 32'h0, {31'h0, flush[p]});
        end
    endtask : fire

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            $display("MISMATCH timeout expected done seen hang");
            bad_count++;
            final_report();
        end
    end

    initial begin
        {rst, rd, wr, addr, wdata, be, go, answer, offer} = '0;
        rst = 1'b1;
        pins = 4'hF;
        repeat (5) @(posedge clk);
        chk("waitreq_rst", 32'h1, {31'h0, waitreq});
        rst <= 1'b0;
        bus(1'b0, G, 32'h0, 4'hF, q);
        chk("global_rst", 32'h0023014F, q);
        chk("div2_rst", 32'h1, {31'h0, div2});
        bus(1'b0, L, 32'h0, 4'hF, q);
        chk("ctl_rst", 32'h7FFF04C8, q);
        chk("swap_rst", 32'h3, 32'(cfg[4:3]));
        // main pll taken as disabled while the prescaler codes are swept
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, rows[i].b, q);
            bus(1'b0, rows[i].a, 32'h0, 4'hF, q);
            chk("readback", rows[i].e, q);
            if (rows[i].a == G) begin
                chk("gcfg", rows[i].e, gcfg);
                chk("divider", 32'(rows[i].e[21:20]), 32'(div));
                chk("div2", 32'(rows[i].e[21:20] == 2'h2), 32'(div2));
            end
        end
        foreach (cv[i]) begin
            bus(1'b1, L, cv[i], 4'hF, q);
            @(negedge clk);
            chk("cfg_hi", 32'(ce[i][11:7]), 32'(cfg[11:7]));
            chk("cfg_lb", 32'(ce[i][6:5]), 32'(cfg[6:5]));
            chk("cfg_rev", 32'(ce[i][4:3]), 32'(cfg[4:3]));
            chk("cfg_lo", 32'(ce[i][2:0]), 32'(cfg[2:0]));
        end
        // full odd reset goes through power-down, soft reset left clear
        bus(1'b1, L, 32'h00000008, 4'hF, q);
        @(negedge clk);
        chk("odd_pd", 32'h1, 32'(cfg[2:0]));
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, L, 32'h80010000, 4'hF, q);
            fire(p, 2 * UNIT + 1);
            @(posedge clk);
            offer[p] <= 1'b1;
            @(posedge clk);
            offer[p] <= 1'b0;
            repeat (2) @(negedge clk);
            chk("drop", 32'h1, {31'h0, drop[p]});
            chk("dead_stays", 32'h1, {31'h0, dead[p]});
            @(posedge clk);
            answer[p] <= 1'b1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("dead_cleared", 32'h0, {31'h0, dead[p]});
            @(posedge clk);
            answer[p] <= 1'b0;
        end
        bus(1'b1, L, 32'h80000000, 4'hF, q);
        fire(0, 0);
        bus(1'b1, L, 32'h00010000, 4'hF, q);
        fire(1, 0);
        @(posedge clk);
        pins <= 4'h0;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, L, 32'h0, 4'hF, q);
        chk("ctl_rst2", 32'h7FFF0000, q);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
